// ==== verilog/tvd_top.sv ====
// Behaviour
// - all pixel and control inputs are captured only on the conversion clock rising edge.
// - red, green and blue outputs all change together from one registered set.
// - each channel's 4-bit value is decoded before it is stored.
// - output magnitude follows the registered data value scaled by the common reference.
// - sync overrides data, blank and boost and drives green to full-scale sync level.
// - blank without sync drives all channels below black, ignoring data and boost.
// - boost without sync or blank raises each channel ten percent over its data level.
// - sync acts only on green; red and blue show the blank level during sync.
// - unconnected video control inputs read as inactive; the logic has no pull-downs and relies on external ones.
// - unconnected pixel data bits read as zero; the logic has no pull-downs and relies on external ones.
// - each channel has a complementary output pair moving in opposite directions.
// - green negative output drops to zero at sync, green positive output rises to full.
`include "tvd_map.svh"
`default_nettype none
module tvd_top #(
  parameter int DATA_W = `TVD_DATA_W,
  parameter int DEPTH = `TVD_FIFO_DEPTH
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_B,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [DATA_W-1:0] i_red,
  input wire logic [DATA_W-1:0] i_green,
  input wire logic [DATA_W-1:0] i_blue,
  input wire logic i_sync,
  input wire logic i_blank,
  input wire logic i_brightness_boost,
  output logic [`TVD_LVL_W-1:0] o_red_pos,
  output logic [`TVD_LVL_W-1:0] o_red_neg,
  output logic [`TVD_LVL_W-1:0] o_green_pos,
  output logic [`TVD_LVL_W-1:0] o_green_neg,
  output logic [`TVD_LVL_W-1:0] o_blue_pos,
  output logic [`TVD_LVL_W-1:0] o_blue_neg
);
  localparam int FW = 3 * DATA_W + 3;
  localparam int CODES = 1 << DATA_W;
  localparam int LW = `TVD_LVL_W;

  // thermometer decode, every bit below the code set, as the current switches want
  function automatic logic [CODES-2:0] thermo(input logic [DATA_W-1:0] v);
    logic [CODES-2:0] t;
    t = '0;
    for (int k = 0; k < CODES - 1; k++) begin
      t[k] = (32'(v) > k);
    end
    return t;
  endfunction

  // level code from thermometer count: black + n, boost adds ten percent span
  function automatic logic [LW-1:0] level(input logic [CODES-2:0] t, input logic boost);
    logic [LW-1:0] n;
    n = '0;
    for (int k = 0; k < CODES - 1; k++) begin
      n = n + LW'(t[k]);
    end
    return n + (boost ? `TVD_LVL_BOOST : `TVD_LVL_BLACK);
  endfunction

  logic f_valid, f_ready;
  logic [FW-1:0] f_data, in_word;
  // unconnected pins are expected to sit low via external pull-downs
  assign in_word = {i_sync, i_blank, i_brightness_boost, i_red, i_green, i_blue};

  tvd_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
    .i_clk(I_SYS_CLK),
    .i_rst_b(I_RST_B),
    .i_valid(i_valid),
    .o_ready(o_ready),
    .i_data(in_word),
    .o_valid(f_valid),
    .i_ready(f_ready),
    .o_data(f_data)
  );
  // stream consumed at pixel rate, one word per edge
  assign f_ready = 1'b1;

  logic [CODES-2:0] th_r [3];
  logic [CODES-2:0] th_nxt [3];
  tvd_pkg::tvd_mode_t mode_r, mode_nxt;
  logic [LW-1:0] lvl [3];

  always_comb begin
    mode_nxt = mode_r;
    for (int c = 0; c < 3; c++) begin
      th_nxt[c] = th_r[c];
    end
    if (f_valid) begin
      for (int c = 0; c < 3; c++) begin
        th_nxt[c] = thermo(f_data[c*DATA_W +: DATA_W]);
      end
      if (f_data[FW-1]) begin
        mode_nxt = tvd_pkg::TVD_MODE_SYNC;
      end else if (f_data[FW-2]) begin
        mode_nxt = tvd_pkg::TVD_MODE_BLANK;
      end else if (f_data[FW-3]) begin
        mode_nxt = tvd_pkg::TVD_MODE_BOOST;
      end else begin
        mode_nxt = tvd_pkg::TVD_MODE_DATA;
      end
    end
  end

  // capture only at the clock edge, all channels from one set
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      mode_r <= tvd_pkg::TVD_MODE_BLANK;
      for (int c = 0; c < 3; c++) begin
        th_r[c] <= '0;
      end
    end else begin
      mode_r <= mode_nxt;
      for (int c = 0; c < 3; c++) begin
        th_r[c] <= th_nxt[c];
      end
    end
  end

  // index 0 blue, 1 green, 2 red
  generate
    for (genvar c = 0; c < 3; c++) begin : g_chan
      always_comb begin
        case (mode_r)
          tvd_pkg::TVD_MODE_SYNC: begin
            lvl[c] = (c == 1) ? `TVD_LVL_SYNC : `TVD_LVL_BLANK;
          end
          tvd_pkg::TVD_MODE_BLANK: begin
            lvl[c] = `TVD_LVL_BLANK;
          end
          tvd_pkg::TVD_MODE_BOOST: begin
            lvl[c] = level(th_r[c], 1'b1);
          end
          default: begin
            lvl[c] = level(th_r[c], 1'b0);
          end
        endcase
      end
    end
  endgenerate

  // positive output rises with level; sync on green gives max, negative zero
  always_comb begin
    // red and blue carry no sync path, so they simply sit at blank
    o_blue_pos = lvl[0];
    o_green_pos = (mode_r == tvd_pkg::TVD_MODE_SYNC) ? `TVD_LVL_MAX : lvl[1];
    o_red_pos = lvl[2];
    o_blue_neg = ~o_blue_pos;
    o_green_neg = ~o_green_pos;
    o_red_neg = ~o_red_pos;
  end

  a_sync_green: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    (f_valid && f_data[FW-1]) |=> (o_green_pos == `TVD_LVL_MAX && o_green_neg == '0))
    else $error("sync did not drive green");
  a_sync_redblue: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    (f_valid && f_data[FW-1]) |=> (o_red_pos == `TVD_LVL_BLANK && o_blue_pos == `TVD_LVL_BLANK))
    else $error("sync leaked to red or blue");
  a_blank_level: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    (f_valid && !f_data[FW-1] && f_data[FW-2]) |=> (o_red_pos == `TVD_LVL_BLANK
      && o_green_pos == `TVD_LVL_BLANK && o_blue_pos == `TVD_LVL_BLANK))
    else $error("blank level wrong");
  a_boost_level: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    (f_valid && f_data[FW-1:FW-3] == 3'h1 && f_data[3:0] == 4'h0)
      |=> (o_blue_pos == `TVD_LVL_BOOST))
    else $error("boost level wrong");
  a_data_level: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    (f_valid && f_data[FW-1:FW-3] == 3'h0)
      |=> (o_blue_pos == `TVD_LVL_BLACK + LW'($past(f_data[3:0]))))
    else $error("data level wrong");
  a_comp_pair: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    (o_red_pos + o_red_neg == `TVD_LVL_MAX) && (o_green_pos + o_green_neg == `TVD_LVL_MAX))
    else $error("outputs not complementary");
  a_hold_idle: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    !f_valid |=> $stable(o_red_pos) && $stable(o_green_pos) && $stable(o_blue_pos))
    else $error("outputs moved without capture");
  a_green_thermo: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    f_valid |=> (th_r[1] == thermo($past(f_data[2*DATA_W-1:DATA_W]))))
    else $error("decode not stored");
endmodule
`default_nettype wire

// ==== verilog/tvd_map.svh ====
`ifndef TVD_MAP_SVH
`define TVD_MAP_SVH
`define TVD_DATA_W 4
`define TVD_LVL_W 5
`define TVD_LVL_SYNC 5'h00
`define TVD_LVL_BLANK 5'h01
`define TVD_LVL_BLACK 5'h02
// boost base is black plus two steps, about ten percent of the 15-step span
`define TVD_LVL_BOOST 5'h04
`define TVD_LVL_MAX 5'h1F
`define TVD_FIFO_DEPTH 16
`endif

// ==== verilog/tvd_pkg.sv ====
`default_nettype none
package tvd_pkg;
  typedef enum logic [1:0] {
    TVD_MODE_DATA,
    TVD_MODE_BOOST,
    TVD_MODE_BLANK,
    TVD_MODE_SYNC
  } tvd_mode_t;
endpackage
`default_nettype wire

// ==== verilog/tvd_fifo.sv ====
`include "tvd_map.svh"
`default_nettype none
module tvd_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = `TVD_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic wr, rd;
  always_comb begin
    o_ready = (cnt_r != DEPTH[AW:0]);
    o_valid = (cnt_r != '0);
    o_data = mem_r[rp_r];
    wr = i_valid && o_ready;
    rd = o_valid && i_ready;
    wp_nxt = wr ? wp_r + 1'b1 : wp_r;
    rp_nxt = rd ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (wr) begin
      mem_r[wp_r] <= i_data;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tvd_gfx_src.sv ====
`default_nettype none
module tvd_gfx_src (
  input wire logic i_clk,
  output logic o_valid,
  output logic [3:0] o_red,
  output logic [3:0] o_green,
  output logic [3:0] o_blue,
  output logic o_sync,
  output logic o_blank,
  output logic o_boost
);
  logic [11:0] last_r;
  initial begin
    o_valid = 1'b0;
    {o_sync, o_blank, o_boost, o_red, o_green, o_blue} = 15'h0000;
    last_r = 12'h000;
  end
  // called just after a rising edge; idle words are inverted junk so a stray
  // capture of an unoffered word shows up at the outputs
  task automatic put(input logic [14:0] w, input logic v);
    o_valid <= v;
    if (v) begin
      last_r = w[11:0];
      {o_sync, o_blank, o_boost, o_red, o_green, o_blue} <= w;
    end else begin
      {o_sync, o_blank, o_boost, o_red, o_green, o_blue} <= {3'h7, ~last_r};
    end
  endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`include "tvd_map.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, valid, ready, sync, blank, boost;
  logic [3:0] r, g, b;
  logic [4:0] op[3], on[3];
  int error_cnt, cmp_count;
  logic [14:0] last_w, q[$];
  logic v[$];
  tvd_gfx_src src (.i_clk(clk), .o_valid(valid), .o_red(r), .o_green(g), .o_blue(b),
    .o_sync(sync), .o_blank(blank), .o_boost(boost));
  tvd_top dut (.I_SYS_CLK(clk), .I_RST_B(rst_b), .i_valid(valid), .o_ready(ready),
    .i_red(r), .i_green(g), .i_blue(b), .i_sync(sync), .i_blank(blank),
    .i_brightness_boost(boost), .o_red_pos(op[0]), .o_red_neg(on[0]),
    .o_green_pos(op[1]), .o_green_neg(on[1]), .o_blue_pos(op[2]), .o_blue_neg(on[2]));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input int c, input logic [4:0] s, input logic [4:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s%0d expected %h seen %h", n, c, e, s);
    end
  endtask
  function automatic logic [4:0] lvl(input logic [14:0] w, input int c);
    logic [3:0] d;
    d = w[11-4*c -: 4];
    if (w[14]) return (c == 1) ? `TVD_LVL_MAX : `TVD_LVL_BLANK;
    if (w[13]) return `TVD_LVL_BLANK;
    if (w[12]) return `TVD_LVL_BOOST + 5'(d);
    return `TVD_LVL_BLACK + 5'(d);
  endfunction
  task automatic chk_all(input logic [14:0] w);
    chk("ready", 0, {4'h0, ready}, 5'h01);
    for (int c = 0; c < 3; c++) begin
      chk("pos", c, op[c], lvl(w, c));
      chk("neg", c, on[c], ~lvl(w, c));
    end
  endtask
  task automatic add(input logic [14:0] w, input logic vv);
    q.push_back(w);
    v.push_back(vv);
  endtask
  // a word offered after edge k is taken at k+1 and shown after k+2
  task automatic run_stream();
    for (int k = 0; k < q.size() + 2; k++) begin
      @(posedge clk);
      if (k < q.size()) src.put(q[k], v[k]);
      else src.put(15'h0000, 1'b0);
      #1;
      if (k >= 2 && v[k-2]) last_w = q[k-2];
      chk_all(last_w);
    end
    q.delete();
    v.delete();
  endtask
  task automatic t_data();
    for (int d = 0; d < 16; d++) add({3'h0, 4'(d), 4'(15 - d), 4'(d ^ 5)}, 1'b1);
    run_stream();
  endtask
  // slow partner: idle cycles between words, boosted codes stay below wrap
  task automatic t_boost();
    for (int d = 0; d < 14; d++) begin
      add({3'h1, 4'(d), 4'(13 - d), 4'(d)}, 1'b1);
      add(15'h7FFF, 1'b0);
    end
    run_stream();
  endtask
  task automatic t_blank();
    for (int d = 0; d < 16; d += 5) begin
      add({3'h2, 4'(d), 4'hF, 4'(d)}, 1'b1);
      add({3'h3, 4'hF, 4'(d), 4'h9}, 1'b1);
      add({3'h0, 4'(d), 4'h1, 4'hE}, 1'b1);
    end
    run_stream();
  endtask
  task automatic t_sync();
    for (int c = 4; c < 8; c++) add({3'(c), 4'hF, 4'h9, 4'h3}, 1'b1);
    add(15'h0000, 1'b1);
    add(15'h4FFF, 1'b1);
    run_stream();
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    last_w = 15'h2000;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk_all(last_w);
    t_data();
    t_boost();
    t_blank();
    t_sync();
    test_done();
  end
  // about 90 cycles expected; generous margin
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire
